// ### hdl/rx_protect_pkg.sv
// constants and types shared by the receiver protection and signalling block
package rx_protect_pkg;

	// clock and time base
	localparam int CLK_NS          = 8;
	localparam int MS_NS           = 1000000;
	localparam int MS_CYCLES       = MS_NS / CLK_NS;
	localparam int HALF_BIT_NS     = 250000;
	localparam int HALF_BIT_CYCLES = HALF_BIT_NS / CLK_NS;

	// periods and windows, in milliseconds
	localparam logic [7:0] ERR_FAST_MS   = 8'h20;
	localparam logic [7:0] ERR_SLOW_MS   = 8'hFA;
	localparam logic [6:0] BIAS_MS       = 7'h19;
	localparam logic [6:0] MONITOR_MS    = 7'h64;
	localparam logic [3:0] DEGLITCH_MS   = 4'hA;

	// packet headers and end-power-transfer reason codes
	localparam logic [7:0] EPT_HEADER      = 8'h02;
	localparam logic [7:0] ERR_HEADER      = 8'h03;
	localparam logic [7:0] REASON_UNKNOWN  = 8'h00;
	localparam logic [7:0] REASON_COMPLETE = 8'h01;
	localparam logic [7:0] REASON_INTERNAL = 8'h02;
	localparam logic [7:0] REASON_OVERTEMP = 8'h03;
	localparam logic [7:0] REASON_BATTFAIL = 8'h06;
	localparam logic [7:0] REASON_NORESP   = 8'h08;

	// packet framing: header, payload, check byte
	localparam logic [4:0] PKT_BITS = 5'h18;

	// temperature-sense comparator channels
	localparam int CH_HOT   = 0;
	localparam int CH_COLD  = 1;
	localparam int CH_LOW   = 2;
	localparam int CH_HIGH  = 3;
	localparam int CH_COUNT = 4;

	typedef enum logic [1:0] {
		RECTIFIER_NODE_DIODE = 2'b00,
		RECTIFIER_NODE_HALF  = 2'b01,
		RECTIFIER_NODE_FULL  = 2'b10
	} rectifier_node_mode_t;

	typedef enum logic {
		TS_BIAS    = 1'b0,
		TS_MONITOR = 1'b1
	} ts_phase_t;

endpackage

// ### hdl/mod_link_if.sv
// packet request and switch state between controller and modulator
`timescale 1ns/1ns
interface mod_link_if;
	logic       start;
	logic [7:0] header;
	logic [7:0] payload;
	logic       busy;
	logic       switchOn;

	modport ctrl (output start, output header, output payload, input busy, input switchOn);
	modport mod  (input start, input header, input payload, output busy, output switchOn);
endinterface

// ### hdl/tick_divider.sv
// divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ns
module tick_divider #(
	parameter int DIV = 125000
) (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	output logic      tick
);
	localparam int W = $clog2(DIV);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} div_t;

	div_t st_reg;
	div_t st_next;

	if (DIV < 2)
	begin : g_chk
		$error("tick_divider: DIV must be at least 2");
	end

	// wrap counter, pulse on wrap
	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == W'(DIV - 1))
		begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end
		else
		begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick = st_reg.tick;
endmodule

// ### hdl/packet_modulator.sv
// serialises a packet as biphase toggles of the load switch
`timescale 1ns/1ns
module packet_modulator (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic halfTick,
	mod_link_if.mod   link
);
	typedef struct packed {
		logic        busy;
		logic [23:0] shreg;
		logic [4:0]  bitsLeft;
		logic        secondHalf;
		logic        sw;
	} mod_t;

	mod_t st_reg;
	mod_t st_next;

	// toggle at every bit start, again mid-bit for a one
	always_comb
	begin
		st_next = st_reg;
		if (!st_reg.busy && link.start)
		begin
			st_next.busy = 1'b1;
			st_next.shreg = {link.header, link.payload, link.header ^ link.payload};
			st_next.bitsLeft = rx_protect_pkg::PKT_BITS;
			st_next.secondHalf = 1'b0;
		end
		else if (st_reg.busy && halfTick)
		begin
			if (!st_reg.secondHalf)
			begin
				st_next.sw = ~st_reg.sw;
				st_next.secondHalf = 1'b1;
			end
			else
			begin
				if (st_reg.shreg[23])
					st_next.sw = ~st_reg.sw;
				st_next.shreg = {st_reg.shreg[22:0], 1'b0};
				st_next.secondHalf = 1'b0;
				st_next.bitsLeft = st_reg.bitsLeft - 1'b1;
				if (st_reg.bitsLeft == 5'h01)
				begin
					st_next.busy = 1'b0;
					st_next.sw = 1'b0; // leave the coil unloaded
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign link.busy = st_reg.busy;
	assign link.switchOn = st_reg.sw;
endmodule

// ### hdl/wireless_rx_protection_signaling.sv
// receiver protection, end-transfer signalling and rectifier mode control
`timescale 1ns/1ns
module wireless_rx_protection_signaling #(
	parameter int MS_CYCLES       = rx_protect_pkg::MS_CYCLES,
	parameter int HALF_BIT_CYCLES = rx_protect_pkg::HALF_BIT_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       rectSurge,
	input  wire logic       rectAcceptable,
	input  wire logic       inputOverVolt,
	input  wire logic       rectConverged,
	input  wire logic       rectConvergeFail,
	input  wire logic       rectAboveUvlo,
	input  wire logic       loadAboveEntry,
	input  wire logic       loadBelowExit,
	input  wire logic       taperMode,
	input  wire logic       battBelowTerm,
	input  wire logic       dieOverTemp,
	input  wire logic       limitResistorShort,
	input  wire logic       prechargeTimeout,
	input  wire logic       fastChargeTimeout,
	input  wire logic       tsHot,
	input  wire logic       tsCold,
	input  wire logic       tsBelowCtrlLow,
	input  wire logic       tsAboveCtrlHigh,
	input  wire logic [7:0] controlError,
	output logic            passFetOn,
	output logic            lowerRectRequest,
	output logic            chargeStatusOutputOut,
	output logic            chargeStatusOutputOe,
	output logic            chargerHighZ,
	output logic            modulationSwitchA,
	output logic            modulationSwitchB,
	output logic            commCurrentLimit,
	output logic [1:0]      rectMode,
	output logic            senseBiasWindow,
	output logic            eptSentFlag,
	output logic [7:0]      eptReasonOut
);
	typedef struct packed {
		logic                           errActive;
		logic                           errFast;
		logic                           errPend;
		logic [7:0]                     errMs;
		logic                           eptLatched;
		logic                           eptSent;
		logic [7:0]                     eptReason;
		logic                           convergedSeen;
		logic                           chargerOn;
		logic                           highZ;
		rx_protect_pkg::rectifier_node_mode_t     rectifier_node;
		rx_protect_pkg::ts_phase_t      ts;
		logic [6:0]                     tsMs;
		logic [rx_protect_pkg::CH_COUNT-1:0][3:0] dgl;
		logic [rx_protect_pkg::CH_COUNT-1:0]      tsFlag;
		logic                           start;
		logic [7:0]                     hdr;
		logic [7:0]                     pay;
	} ctl_t;

	ctl_t st_reg;
	ctl_t st_next;

	logic                                msTick;
	logic                                halfTick;
	logic                                tsFault;
	logic                                eptCond;
	logic [7:0]                          reasonNow;
	logic [7:0]                          errPeriod;
	logic [rx_protect_pkg::CH_COUNT-1:0] chIn;
	logic [rx_protect_pkg::CH_COUNT-1:0] chWin;

	mod_link_if link ();

	// millisecond and half-bit time bases
	tick_divider #(.DIV(MS_CYCLES)) u_ms (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.tick    (msTick)
	);

	tick_divider #(.DIV(HALF_BIT_CYCLES)) u_bit (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.tick    (halfTick)
	);

	packet_modulator u_mod (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.halfTick (halfTick),
		.link     (link.mod)
	);

	// comparator channels and the phase in which each is read
	assign chIn = {tsAboveCtrlHigh, tsBelowCtrlLow, tsCold, tsHot};
	assign chWin = (st_reg.ts == rx_protect_pkg::TS_BIAS) ? 4'h7 : 4'h8;
	assign tsFault = st_reg.tsFlag[rx_protect_pkg::CH_HOT]
		| st_reg.tsFlag[rx_protect_pkg::CH_COLD]
		| st_reg.tsFlag[rx_protect_pkg::CH_LOW];

	// reason priority: fault, temperature, battery, convergence, control, done
	assign reasonNow =
		(dieOverTemp || limitResistorShort) ? rx_protect_pkg::REASON_INTERNAL :
		tsFault ? rx_protect_pkg::REASON_OVERTEMP :
		(prechargeTimeout || fastChargeTimeout) ? rx_protect_pkg::REASON_BATTFAIL :
		rectConvergeFail ? rx_protect_pkg::REASON_NORESP :
		st_reg.tsFlag[rx_protect_pkg::CH_HIGH] ? rx_protect_pkg::REASON_UNKNOWN :
		rx_protect_pkg::REASON_COMPLETE;
	assign eptCond = dieOverTemp | limitResistorShort | tsFault | prechargeTimeout
		| fastChargeTimeout | rectConvergeFail | st_reg.tsFlag[rx_protect_pkg::CH_HIGH]
		| (taperMode & battBelowTerm);

	assign errPeriod = st_reg.errFast ? rx_protect_pkg::ERR_FAST_MS
		: rx_protect_pkg::ERR_SLOW_MS;

	// whole control state
	always_comb
	begin
		st_next = st_reg;
		st_next.start = 1'b0;

		// surge starts fast error reporting, acceptable level slows it
		if (rectSurge || inputOverVolt)
		begin
			st_next.errActive = 1'b1;
			st_next.errFast = 1'b1;
		end
		else if (rectAcceptable)
			st_next.errFast = 1'b0;

		// latch the first end-transfer cause
		if (eptCond && !st_reg.eptLatched)
		begin
			st_next.eptLatched = 1'b1;
			st_next.eptReason = reasonNow;
		end

		// one packet at a time; end-transfer beats error reports
		if (!link.busy && !st_reg.start)
		begin
			if (st_reg.eptLatched && !st_reg.eptSent)
			begin
				st_next.start = 1'b1;
				st_next.hdr = rx_protect_pkg::EPT_HEADER;
				st_next.pay = st_reg.eptReason;
				st_next.eptSent = 1'b1;
			end
			else if (st_reg.errPend && !st_reg.eptLatched)
			begin
				st_next.start = 1'b1;
				st_next.hdr = rx_protect_pkg::ERR_HEADER;
				st_next.pay = controlError;
				st_next.errPend = 1'b0;
			end
		end

		// report timer after the start, so a new due report beats the clear
		if (st_reg.errActive && !st_reg.eptLatched && msTick)
		begin
			if (st_reg.errMs == errPeriod - 8'h01)
			begin
				st_next.errMs = '0;
				st_next.errPend = 1'b1;
			end
			else
				st_next.errMs = st_reg.errMs + 8'h01;
		end

		// charger output gated by convergence, overvoltage and faults
		if (rectConverged)
			st_next.convergedSeen = 1'b1;
		st_next.chargerOn = st_reg.convergedSeen && !inputOverVolt && !st_reg.eptLatched
			&& !dieOverTemp && !tsFault;
		if (st_reg.eptSent && st_reg.eptReason == rx_protect_pkg::REASON_COMPLETE)
			st_next.highZ = 1'b1;

		// rectifier mode
		if (!rectAboveUvlo)
			st_next.rectifier_node = rx_protect_pkg::RECTIFIER_NODE_DIODE;
		else
		begin
			unique case (st_reg.rectifier_node)
				rx_protect_pkg::RECTIFIER_NODE_DIODE: st_next.rectifier_node = rx_protect_pkg::RECTIFIER_NODE_HALF;
				rx_protect_pkg::RECTIFIER_NODE_HALF:
					if (loadAboveEntry)
						st_next.rectifier_node = rx_protect_pkg::RECTIFIER_NODE_FULL;
				rx_protect_pkg::RECTIFIER_NODE_FULL:
					if (loadBelowExit)
						st_next.rectifier_node = rx_protect_pkg::RECTIFIER_NODE_HALF;
				default: st_next.rectifier_node = rx_protect_pkg::RECTIFIER_NODE_DIODE;
			endcase
		end

		// sense pin bias and monitor windows
		if (msTick)
		begin
			unique case (st_reg.ts)
				rx_protect_pkg::TS_BIAS:
					if (st_reg.tsMs == rx_protect_pkg::BIAS_MS - 7'h01)
					begin
						st_next.ts = rx_protect_pkg::TS_MONITOR;
						st_next.tsMs = '0;
					end
					else
						st_next.tsMs = st_reg.tsMs + 7'h01;
				rx_protect_pkg::TS_MONITOR:
					if (st_reg.tsMs == rx_protect_pkg::MONITOR_MS - 7'h01)
					begin
						st_next.ts = rx_protect_pkg::TS_BIAS;
						st_next.tsMs = '0;
					end
					else
						st_next.tsMs = st_reg.tsMs + 7'h01;
			endcase
		end

		// deglitch each comparator inside its window
		for (int i = 0; i < rx_protect_pkg::CH_COUNT; i++)
		begin
			if (!chIn[i] || !chWin[i])
				st_next.dgl[i] = '0;
			else if (msTick && st_reg.dgl[i] != rx_protect_pkg::DEGLITCH_MS)
				st_next.dgl[i] = st_reg.dgl[i] + 4'h1;
			if (st_reg.dgl[i] == rx_protect_pkg::DEGLITCH_MS)
				st_next.tsFlag[i] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// modulator request
	assign link.start = st_reg.start;
	assign link.header = st_reg.hdr;
	assign link.payload = st_reg.pay;

	// outputs
	assign passFetOn = st_reg.chargerOn;
	assign lowerRectRequest = inputOverVolt;
	assign chargeStatusOutputOut = 1'b0;
	assign chargeStatusOutputOe = st_reg.chargerOn;
	assign chargerHighZ = st_reg.highZ;
	assign modulationSwitchA = link.switchOn;
	assign modulationSwitchB = link.switchOn;
	assign commCurrentLimit = link.busy;
	assign rectMode = st_reg.rectifier_node;
	assign senseBiasWindow = (st_reg.ts == rx_protect_pkg::TS_BIAS);
	assign eptSentFlag = st_reg.eptSent;
	assign eptReasonOut = st_reg.eptReason;

	sequence biasEnd_s;
		msTick && st_reg.ts == rx_protect_pkg::TS_BIAS
			&& st_reg.tsMs == rx_protect_pkg::BIAS_MS - 7'h01;
	endsequence
	sequence monitorStart_s;
		st_reg.ts == rx_protect_pkg::TS_MONITOR && st_reg.tsMs == 7'h00 && !senseBiasWindow;
	endsequence

	error_period_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(st_reg.errActive && st_reg.errFast && !st_reg.eptLatched && msTick
			&& st_reg.errMs == rx_protect_pkg::ERR_FAST_MS - 8'h01)
		|=> (st_reg.errPend && st_reg.errMs == 8'h00))
		else $error("fast error packet not due after 32 ms");
	overvolt_fet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		inputOverVolt |=> !passFetOn)
		else $error("pass transistor on during overvoltage");
	ept_header_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(st_reg.eptSent) |-> (link.start && link.header == rx_protect_pkg::EPT_HEADER
			&& link.payload == st_reg.eptReason))
		else $error("end-transfer packet framed wrongly");
	charge_done_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		($rose(st_reg.eptLatched) && st_reg.eptReason == rx_protect_pkg::REASON_COMPLETE)
		|-> $past(taperMode && battBelowTerm))
		else $error("charge complete without termination");
	internal_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!st_reg.eptLatched && dieOverTemp)
		|=> (st_reg.eptLatched && st_reg.eptReason == rx_protect_pkg::REASON_INTERNAL))
		else $error("internal fault reason missing");
	batt_fail_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!st_reg.eptLatched && fastChargeTimeout && !dieOverTemp && !limitResistorShort
			&& !tsFault) |=> (st_reg.eptReason == rx_protect_pkg::REASON_BATTFAIL))
		else $error("battery failure reason missing");
	no_response_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		($rose(st_reg.eptLatched) && st_reg.eptReason == rx_protect_pkg::REASON_NORESP)
		|-> $past(rectConvergeFail))
		else $error("no-response reason without cause");
	charger_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!st_reg.convergedSeen || st_reg.eptLatched) |=> !chargeStatusOutputOe)
		else $error("status output on with charger disabled");
	switch_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(modulationSwitchA || modulationSwitchB)
		|-> (modulationSwitchA == modulationSwitchB && commCurrentLimit))
		else $error("switches split or limit not lowered");
	rectifier_node_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!rectAboveUvlo |=> rectMode == rx_protect_pkg::RECTIFIER_NODE_DIODE)
		and ((rectAboveUvlo && st_reg.rectifier_node == rx_protect_pkg::RECTIFIER_NODE_HALF && loadAboveEntry)
			|=> rectMode == rx_protect_pkg::RECTIFIER_NODE_FULL))
		else $error("rectifier mode wrong");
	overtemp_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		($rose(st_reg.eptLatched) && st_reg.eptReason == rx_protect_pkg::REASON_OVERTEMP)
		|-> $past(tsFault))
		else $error("overtemperature reason without flag");
	bias_window_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		biasEnd_s |=> monitorStart_s)
		else $error("bias window not 25 ms");
	high_z_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(chargerHighZ) |-> (st_reg.eptSent && !chargeStatusOutputOe))
		else $error("high impedance before notice");
endmodule

// ### tb/tx_controller_model.sv
// transmitter controller model: decodes load-modulation frames from the switch
`timescale 1ns/1ns
module tx_controller_model #(
	parameter int HB = 4
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        switchLine,
	output logic             powerOn,
	output logic             frameDone,
	output logic [23:0]      frame
);
	int          gap;
	int          nBits;
	logic        half;
	logic        prev;
	logic        inFrame;
	logic        toggled;
	logic        b;
	logic [23:0] sr;

	// one long gap between toggles is a 0, two short ones a 1; silence ends a bit
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			powerOn   <= 1'b1;
			frameDone <= 1'b0;
			inFrame    = 1'b0;
			prev       = 1'b0;
			gap        = 0;
		end
		else
		begin
			frameDone <= 1'b0;
			toggled    = (switchLine !== prev);
			prev       = switchLine;
			gap        = gap + 1;
			if (!inFrame)
			begin
				inFrame = toggled;
				gap     = 0;
				nBits   = 0;
				half    = 1'b0;
			end
			else if (toggled && gap * 2 < 3 * HB && !half)
			begin
				half = 1'b1;
				gap  = 0;
			end
			else if (toggled || gap > 3 * HB)
			begin
				b     = toggled ? (gap * 2 < 3 * HB) : half;
				sr    = {sr[22:0], b};
				nBits = nBits + 1;
				half  = 1'b0;
				gap   = 0;
				if (nBits == 24)
				begin
					frame     <= sr;
					frameDone <= 1'b1;
					inFrame    = 1'b0;
					// end-transfer frame stops power delivery
					if (sr[23:16] == rx_protect_pkg::EPT_HEADER)
						powerOn <= 1'b0;
				end
			end
		end
	end
endmodule

// ### tb/tb_wireless_rx_protection_signaling.sv
// self-checking bench for the receiver protection and signalling block
`timescale 1ns/1ns
`define CHECK(got, exp, msg) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			badCount++; \
			$display("CHECK FAILED %0t %s", $time, msg); \
		end \
	end
module tb_wireless_rx_protection_signaling;
	localparam int MSC = 10;
	localparam int HB  = 4;
	localparam logic [10:0] CAUSES [11] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h010,
		11'h020, 11'h040, 11'h080, 11'h100, 11'h600, 11'h021};
	localparam logic [7:0] REASONS [11] = '{8'h02, 8'h02, 8'h03, 8'h03, 8'h03,
		8'h06, 8'h06, 8'h08, 8'h00, 8'h01, 8'h02};

	logic        ref_clk, rst_b;
	logic        rectSurge, rectAcceptable, inputOverVolt, rectConverged;
	logic        rectAboveUvlo, loadAboveEntry, loadBelowExit;
	logic [10:0] cause;
	logic [7:0]  controlError;
	logic        passFetOn, lowerRectRequest, chgOut, chgOe, chargerHighZ;
	logic        swA, swB, commCurrentLimit, senseBiasWindow, eptSentFlag;
	logic [1:0]  rectMode;
	logic [7:0]  eptReasonOut;
	logic        powerOn, frameDone;
	logic [23:0] frame;
	logic [23:0] expQ [$];
	logic [31:0] seed = 32'h0000000A;
	int          badCount = 0;
	int          compares = 0;

	wireless_rx_protection_signaling #(.MS_CYCLES(MSC), .HALF_BIT_CYCLES(HB)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .rectSurge(rectSurge),
		.rectAcceptable(rectAcceptable), .inputOverVolt(inputOverVolt),
		.rectConverged(rectConverged), .rectConvergeFail(cause[7]),
		.rectAboveUvlo(rectAboveUvlo), .loadAboveEntry(loadAboveEntry),
		.loadBelowExit(loadBelowExit), .taperMode(cause[9]), .battBelowTerm(cause[10]),
		.dieOverTemp(cause[0]), .limitResistorShort(cause[1]),
		.prechargeTimeout(cause[5]), .fastChargeTimeout(cause[6]), .tsHot(cause[2]),
		.tsCold(cause[3]), .tsBelowCtrlLow(cause[4]), .tsAboveCtrlHigh(cause[8]),
		.controlError(controlError), .passFetOn(passFetOn),
		.lowerRectRequest(lowerRectRequest), .chargeStatusOutputOut(chgOut),
		.chargeStatusOutputOe(chgOe), .chargerHighZ(chargerHighZ),
		.modulationSwitchA(swA), .modulationSwitchB(swB),
		.commCurrentLimit(commCurrentLimit), .rectMode(rectMode),
		.senseBiasWindow(senseBiasWindow), .eptSentFlag(eptSentFlag),
		.eptReasonOut(eptReasonOut));

	tx_controller_model #(.HB(HB)) partner (.ref_clk(ref_clk), .rst_b(rst_b),
		.switchLine(swA), .powerOn(powerOn), .frameDone(frameDone), .frame(frame));

	// free-running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// xorshift source for error payloads
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	function automatic logic probe(input int w);
		case (w)
			0: return commCurrentLimit;
			1: return eptSentFlag;
			default: return senseBiasWindow;
		endcase
	endfunction

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// count cycles until a watched output leaves a level, bounded
	task automatic run(input int w, input logic lvl, input int limit, output int n);
		n = 0;
		while (probe(w) === lvl)
		begin
			@(negedge ref_clk);
			n++;
			if (n > limit)
			begin
				badCount++;
				$display("CHECK FAILED %0t wait ran out", $time);
				tally_and_finish();
			end
		end
	endtask

	task automatic near(input int n, input int exp, input int tol);
		`CHECK(n >= exp - tol && n <= exp + tol, 1'b1, "timing off")
	endtask

	task automatic do_reset();
		rst_b = 1'b0;
		cause = '0;
		{rectSurge, rectAcceptable, inputOverVolt, rectConverged} = 4'h0;
		{rectAboveUvlo, loadAboveEntry, loadBelowExit} = 3'h0;
		repeat (10) @(negedge ref_clk);
		rst_b = 1'b1;
	endtask

	// note each error frame at its start, check spacing and busy length
	task automatic err_packets(input int cnt, input int ms);
		int         n;
		int         len;
		logic [7:0] ce;
		for (int k = 0; k < cnt; k++)
		begin
			run(0, 1'b0, 3000 * MSC, n);
			ce = controlError;
			expQ.push_back({rx_protect_pkg::ERR_HEADER, ce, rx_protect_pkg::ERR_HEADER ^ ce});
			if (k > 0)
				near(n + len + 1, ms * MSC, MSC);
			@(negedge ref_clk);
			controlError = rnd();
			run(0, 1'b1, 60 * HB, len);
			near(len + 1, 48 * HB, HB + 2);
		end
	endtask

	// frames seen by the transmitter against the oldest note
	always @(posedge ref_clk)
	begin
		if (frameDone === 1'b1)
		begin
			if (expQ.size() == 0)
				`CHECK(1'b0, 1'b1, "unexpected frame")
			else
				`CHECK(frame, expQ.pop_front(), "frame content")
		end
	end

	// both switches move together, and only under the lowered limit
	always @(negedge ref_clk)
	begin
		if (rst_b === 1'b1)
		begin
			`CHECK(swB, swA, "switches differ")
			if (swA === 1'b1)
				`CHECK(commCurrentLimit, 1'b1, "limit not lowered")
		end
	end

	// main sequence
	initial
	begin
		int         n;
		logic [7:0] r;
		controlError = rnd();
		do_reset();
		`CHECK(rectMode, rx_protect_pkg::RECTIFIER_NODE_DIODE, "start-up mode")
		`CHECK(senseBiasWindow, 1'b1, "bias at start")
		run(2, 1'b1, 40 * MSC, n);
		near(n, 25 * MSC, MSC);
		run(2, 1'b0, 120 * MSC, n);
		near(n, 100 * MSC, MSC);
		`CHECK(chgOe, 1'b0, "output before converge")
		rectAboveUvlo = 1'b1;
		repeat (2) @(negedge ref_clk);
		`CHECK(rectMode, rx_protect_pkg::RECTIFIER_NODE_HALF, "half sync")
		loadAboveEntry = 1'b1;
		repeat (2) @(negedge ref_clk);
		`CHECK(rectMode, rx_protect_pkg::RECTIFIER_NODE_FULL, "full sync")
		loadAboveEntry = 1'b0;
		loadBelowExit = 1'b1;
		repeat (2) @(negedge ref_clk);
		`CHECK(rectMode, rx_protect_pkg::RECTIFIER_NODE_HALF, "back to half")
		rectConverged = 1'b1;
		repeat (3) @(negedge ref_clk);
		`CHECK({chgOe, chgOut}, 2'b10, "status pin")
		inputOverVolt = 1'b1;
		#1;
		`CHECK(lowerRectRequest, 1'b1, "lower request")
		repeat (2) @(negedge ref_clk);
		`CHECK(passFetOn, 1'b0, "pass transistor")
		`CHECK(chgOe, 1'b0, "status after overvoltage")
		inputOverVolt = 1'b0;
		rectSurge = 1'b1;
		err_packets(3, 32);
		rectSurge = 1'b0;
		rectAcceptable = 1'b1;
		err_packets(3, 250);
		repeat (6 * HB) @(negedge ref_clk); // last frame decoded before reset
		// every end-transfer cause, one per reset, then die overtemperature with precharge timeout together for priority
		for (int i = 0; i < 11; i++)
		begin
			do_reset();
			rectConverged = ~CAUSES[i][7];
			rectAboveUvlo = 1'b1;
			cause = CAUSES[i];
			run(1, 1'b0, 3000, n);
			r = REASONS[i];
			expQ.push_back({8'h02, r, 8'h02 ^ r});
			@(negedge ref_clk);
			`CHECK(eptReasonOut, r, "reason code")
			cause = 11'h7FF;
			run(0, 1'b0, 100, n);
			run(0, 1'b1, 60 * HB, n);
			repeat (6 * HB) @(negedge ref_clk);
			`CHECK(eptReasonOut, r, "later cause taken")
			`CHECK(powerOn, 1'b0, "power not stopped")
			`CHECK(chargerHighZ, r == 8'h01, "high impedance")
			`CHECK(chgOe, 1'b0, "status still on")
		end
		`CHECK(expQ.size() == 0, 1'b1, "frames missing")
		tally_and_finish();
	end
endmodule
